// [mrsm_alu.sv]
// combinational multiply, reverse subtract, round and saturate stage
`timescale 1ns/1ps
`default_nettype none
module mrsm_alu (
  input  wire mrsm_pkg::mrsm_mode_t   mode_i,
  input  wire logic [15:0]            op1_i,
  input  wire logic [15:0]            op2_i,
  input  wire logic [39:0]            acc_i,
  input  wire mrsm_pkg::mrsm_flags_t  flags_i,
  output var  mrsm_pkg::mrsm_alu_res_t res_o
);
  import mrsm_pkg::*;

  logic        [PROD_W-1:0] uprod;
  logic signed [PROD_W:0]   sprod;
  logic signed [FULL_W-1:0] prod_ext;
  logic signed [FULL_W-1:0] acc_ext;
  logic signed [FULL_W-1:0] full;
  logic                     ovf;
  logic        [ACC_W-1:0]  res;

  always_comb begin
    uprod = op1_i * op2_i;
    sprod = $signed({1'b0, op1_i}) * $signed(op2_i);
    if (mode_i == MRSM_MODE_ROUND) begin
      prod_ext = {{(FULL_W-PROD_W-1){sprod[PROD_W]}}, sprod};
    end else begin
      prod_ext = {{(FULL_W-PROD_W){1'b0}}, uprod};
    end
    acc_ext = {{(FULL_W-ACC_W){acc_i[ACC_W-1]}}, acc_i};
    full    = prod_ext - acc_ext;
    if (mode_i == MRSM_MODE_ROUND) begin
      full = full + $signed({{(FULL_W-ACC_W){1'b0}}, ROUND_CONST});
    end
    // range check on the untruncated value
    ovf = !((&full[FULL_W-1:ACC_W-1]) || !(|full[FULL_W-1:ACC_W-1]));
    if (ovf) begin
      res = full[FULL_W-1] ? SAT_MIN : SAT_MAX;
    end else begin
      res = full[ACC_W-1:0];
    end
    if (mode_i == MRSM_MODE_ROUND) begin
      res[LOW_WORD_W-1:0] = '0;
    end
    res_o.acc       = res;
    res_o.flags.ovf = ovf;
    res_o.flags.lim = flags_i.lim | ovf;
    res_o.flags.ext = !((&res[ACC_W-1:EXT_LSB]) ||
                        !(|res[ACC_W-1:EXT_LSB]));
    res_o.flags.sov = flags_i.sov | ovf;
    res_o.flags.cy  = prod_ext[ACC_W-1:0] < acc_i;
    res_o.flags.z   = (res == '0);
    res_o.flags.n   = res[ACC_W-1];
  end

endmodule // mrsm_alu
`default_nettype wire

// [mrsm_assertions.sv]
// port-level checks for the reverse-subtract mac block
`timescale 1ns/1ps
`default_nettype none
module mrsm_assertions (
  input wire logic                       sys_clk_i,
  input wire logic                       srst_i,
  input wire logic                       psel_i,
  input wire logic                       penable_i,
  input wire logic                       pwrite_i,
  input wire logic [mrsm_pkg::ADDR_W-1:0] paddr_i,
  input wire logic                       pready_o,
  input wire logic                       pslverr_o,
  input wire logic [mrsm_pkg::ACC_W-1:0]  accumulator_40_o,
  input wire mrsm_pkg::mrsm_flags_t      flags_o,
  input wire logic                       done_o
);
  import mrsm_pkg::*;
  // ==========
  // helpers
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  logic [8:0] top9;
  logic       stat_wr;
  assign top9    = accumulator_40_o[39:31];
  assign stat_wr = psel_i && pwrite_i && paddr_i == ADDR_STATUS;
  // ==========
  // assertions
  chk_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready held longer than one cycle");
  chk_err_ready: assert property (pslverr_o |-> pready_o && penable_i)
    else $error("error response outside an access");
  chk_sov_kept: assert property ($fell(flags_o.sov) |-> $past(stat_wr))
    else $error("sticky overflow lost");
  chk_lim_kept: assert property ($fell(flags_o.lim) |-> $past(stat_wr))
    else $error("sticky limit lost");
  chk_ovf_sets: assert property (done_o && flags_o.ovf |-> flags_o.sov && flags_o.lim)
    else $error("overflow without sticky flags");
  chk_neg_msb: assert property (done_o |-> flags_o.n == accumulator_40_o[39])
    else $error("negative flag differs from msb");
  chk_zero_flag: assert property (done_o |-> flags_o.z == (accumulator_40_o == '0))
    else $error("zero flag wrong");
  chk_ext_flag: assert property (done_o |-> flags_o.ext == !(&top9 || ~|top9))
    else $error("extension flag wrong");
  chk_done_pulse: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  cov_ovf: cover property (done_o && flags_o.ovf);
  cov_zero: cover property (done_o && flags_o.z);
  cov_err: cover property (pslverr_o);
endmodule // mrsm_assertions

bind mrsm_top mrsm_assertions u_mrsm_assertions (.sys_clk_i, .srst_i,
  .psel_i, .penable_i, .pwrite_i, .paddr_i, .pready_o, .pslverr_o,
  .accumulator_40_o, .flags_o, .done_o);
`default_nettype wire

// [mrsm_core_model.sv]
// core model issuing instructions and operands over apb
`timescale 1ns/1ps
`default_nettype none
module mrsm_core_model (
  input  wire logic        sys_clk_i,
  output var  logic        psel_o,
  output var  logic        penable_o,
  output var  logic        pwrite_o,
  output var  logic [7:0]  paddr_o,
  output var  logic [31:0] pwdata_o,
  input  wire logic        pready_i,
  input  wire logic [31:0] prdata_i,
  input  wire logic        pslverr_i
);
  import mrsm_pkg::*;
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'hFF;
    pwdata_o = 32'h0;
  end
  // rounding operand implied by the opcode
  function automatic logic [31:0] instr(input logic r, input logic [2:0] m);
    return {OPC_FIRST, 8'h00, r ? OPC_ROUND : OPC_PLAIN, m, 5'h00};
  endfunction
  // ==========
  // one transfer; t stays high if no answer
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e,
      output logic t);
    int n;
    t = 1'b1;
    @(posedge sys_clk_i);
    psel_o <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge sys_clk_i);
    penable_o <= 1'b1;
    for (n = 0; n < 20 && t; n++) begin
      @(posedge sys_clk_i);
      if (pready_i) begin
        t = 1'b0;
        q = prdata_i;
        e = pslverr_i;
      end
    end
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    pwdata_o <= ~d;
  endtask
endmodule // mrsm_core_model
`default_nettype wire

// [mrsm_pkg.sv]
// shared constants and types for the reverse-subtract multiply-accumulate block
package mrsm_pkg;

  // ===========================================================
  // widths
  localparam int DATA_W = 16;
  localparam int PROD_W = 32;
  localparam int ACC_W  = 40;
  localparam int FULL_W = 42;
  localparam int ADDR_W = 8;
  localparam int PMOD_W = 3;

  // ===========================================================
  // instruction encoding
  localparam logic [7:0] OPC_FIRST = 8'h93;
  localparam logic [7:0] OPC_PLAIN = 8'h38;
  localparam logic [7:0] OPC_ROUND = 8'hB9;
  localparam int BYTE0_LSB = 24;
  localparam int BYTE2_LSB = 8;
  localparam int IDX_MOD_LSB = 5;
  localparam int GEN_MOD_LSB = 0;

  // pointer modification codes
  localparam logic [PMOD_W-1:0] PMOD_NONE = 3'h0;
  localparam logic [PMOD_W-1:0] PMOD_INC  = 3'h1;
  localparam logic [PMOD_W-1:0] PMOD_DEC  = 3'h2;
  localparam logic [PMOD_W-1:0] PMOD_ADD  = 3'h3;
  localparam logic [PMOD_W-1:0] PMOD_SUB  = 3'h4;

  // ===========================================================
  // arithmetic constants
  localparam logic [ACC_W-1:0] ROUND_CONST = 40'h00_0000_8000;
  localparam logic [ACC_W-1:0] SAT_MAX     = 40'h7F_FFFF_FFFF;
  localparam logic [ACC_W-1:0] SAT_MIN     = 40'h80_0000_0000;
  localparam int LOW_WORD_W = 16;
  localparam int EXT_LSB    = 31;

  // ===========================================================
  // register map (byte addresses)
  localparam logic [ADDR_W-1:0] ADDR_INSTR  = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_ACC_LO = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_ACC_HI = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_IDX    = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_GEN    = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_STEP   = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_MEM    = 8'h40;

  // status layout
  localparam int ST_FLAG_LSB = 0;
  localparam int ST_LIM_BIT  = 5;
  localparam int ST_SOV_BIT  = 3;
  localparam int ST_BAD_BIT  = 8;
  localparam int ST_BUSY_BIT = 9;

  localparam logic [31:0] INSTR_RESET = 32'h0000_0000;

  // ===========================================================
  // types
  typedef enum logic {MRSM_MODE_PLAIN, MRSM_MODE_ROUND} mrsm_mode_t;

  typedef struct packed {
    logic ovf;
    logic lim;
    logic ext;
    logic sov;
    logic cy;
    logic z;
    logic n;
  } mrsm_flags_t;

  typedef struct packed {
    logic [ACC_W-1:0] acc;
    mrsm_flags_t      flags;
  } mrsm_alu_res_t;

endpackage

// [mrsm_top.sv]
// reverse-subtract multiply-accumulate with parallel move, APB slave
// Overview of operation
// - plain: unsigned 16x16 full product
// - plain: zero-extend 32-bit product
// - plain: product minus accumulator into accumulator
// - round: unsigned times signed, signed product
// - round: sign-extend product, subtract accumulator
// - round: add 8000h before write-back
// - round: clear accumulator low word
// - copy index-pointed word to another word
// - destination follows index pointer modification
// - overflow flag on out-of-range result
// - saturate; sticky limit flag on saturation
// - extension flag when extension part used
// - sticky overflow set, cleared here only by writing one to its status bit
// - carry flag on subtraction borrow
// - zero flag on zero result
// - negative flag copies result msb
// - decode 93h first byte, 38h/B9h third
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module mrsm_top #(
  parameter int DEPTH = 16,
  parameter int PTR_W = 4
) (
  input  wire logic                         sys_clk_i,
  input  wire logic                         srst_i,
  input  wire logic                         psel_i,
  input  wire logic                         penable_i,
  input  wire logic                         pwrite_i,
  input  wire logic [mrsm_pkg::ADDR_W-1:0]  paddr_i,
  input  wire logic [31:0]                  pwdata_i,
  output var  logic                         pready_o,
  output var  logic [31:0]                  prdata_o,
  output var  logic                         pslverr_o,
  output var  logic [mrsm_pkg::ACC_W-1:0]   accumulator_40_o,
  output var  mrsm_pkg::mrsm_flags_t        flags_o,
  output var  logic                         done_o
);
  import mrsm_pkg::*;

  // ===========================================================
  // decode helpers
  function automatic logic mem_hit(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] off;
    off = a - ADDR_MEM;
    mem_hit = (a >= ADDR_MEM) && (a[1:0] == 2'h0) &&
              (int'(off >> 2) < DEPTH);
  endfunction

  function automatic logic [PTR_W-1:0] mem_idx(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] off;
    off = a - ADDR_MEM;
    mem_idx = off[PTR_W+1:2];
  endfunction

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    reg_hit = (a == ADDR_INSTR) || (a == ADDR_STATUS) ||
              (a == ADDR_ACC_LO) || (a == ADDR_ACC_HI) ||
              (a == ADDR_IDX) || (a == ADDR_GEN) ||
              (a == ADDR_STEP) || mem_hit(a);
  endfunction

  // both variants share the first opcode byte
  function automatic logic opc_valid(input logic [31:0] w);
    logic [7:0] opc_hi;
    logic [7:0] opc_mid;
    opc_hi    = w[BYTE0_LSB +: 8];
    opc_mid   = w[BYTE2_LSB +: 8];
    opc_valid = (opc_hi == OPC_FIRST) &&
                ((opc_mid == OPC_PLAIN) || (opc_mid == OPC_ROUND));
  endfunction

  function automatic logic [PTR_W-1:0] ptr_mod(
    input logic [PTR_W-1:0]  p,
    input logic [PMOD_W-1:0] code,
    input logic [PTR_W-1:0]  step);
    // pointers wrap modulo 2**PTR_W, the pointer width
    case (code)
      PMOD_INC: ptr_mod = p + PTR_W'(1);
      PMOD_DEC: ptr_mod = p - PTR_W'(1);
      PMOD_ADD: ptr_mod = p + step;
      PMOD_SUB: ptr_mod = p - step;
      default:  ptr_mod = p;
    endcase
  endfunction

  // ===========================================================
  // state
  typedef enum logic {ST_IDLE, ST_EXEC} mrsm_state_t;

  mrsm_state_t         st_r,      st_nxt;
  logic                pready_r,  pready_nxt;
  logic [31:0]         prdata_r,  prdata_nxt;
  logic                pslverr_r, pslverr_nxt;
  logic [31:0]         instr_r,   instr_nxt;
  logic [ACC_W-1:0]    acc_r,     acc_nxt;
  mrsm_flags_t         flags_r,   flags_nxt;
  logic                bad_r,     bad_nxt;
  logic                done_r,    done_nxt;
  logic [PTR_W-1:0]    idx_r,     idx_nxt;
  logic [PTR_W-1:0]    gen_r,     gen_nxt;
  logic [PTR_W-1:0]    step_r,    step_nxt;
  logic [DATA_W-1:0]   mem_r      [DEPTH];
  logic [DATA_W-1:0]   mem_nxt    [DEPTH];

  logic                acc_taken;
  logic                wr_en;
  logic                exec;
  logic [7:0]          op_third;
  logic [PTR_W-1:0]    dest_ptr;
  mrsm_mode_t          mode;
  mrsm_alu_res_t       alu_res;
  logic [31:0]         rd_data;

  // ===========================================================
  // arithmetic stage
  mrsm_alu u_alu (
    .mode_i  (mode),
    .op1_i   (mem_r[idx_r]),
    .op2_i   (mem_r[gen_r]),
    .acc_i   (acc_r),
    .flags_i (flags_r),
    .res_o   (alu_res)
  );

  // ===========================================================
  // decode and read mux
  always_comb begin
    acc_taken = psel_i && penable_i && pready_r;
    wr_en     = acc_taken && pwrite_i;
    exec      = (st_r == ST_EXEC);
    op_third  = instr_r[BYTE2_LSB +: 8];
    mode      = (op_third == OPC_ROUND) ? MRSM_MODE_ROUND
                                        : MRSM_MODE_PLAIN;
    dest_ptr  = ptr_mod(idx_r, instr_r[IDX_MOD_LSB +: PMOD_W],
                        step_r);
    rd_data   = 32'h0000_0000;
    if (mem_hit(paddr_i)) begin
      rd_data[DATA_W-1:0] = mem_r[mem_idx(paddr_i)];
    end else begin
      case (paddr_i)
        ADDR_INSTR:  rd_data = instr_r;
        ADDR_STATUS: begin
          rd_data[ST_FLAG_LSB +: 7] = flags_r;
          rd_data[ST_BAD_BIT]       = bad_r;
          rd_data[ST_BUSY_BIT]      = exec;
        end
        ADDR_ACC_LO: rd_data = acc_r[31:0];
        ADDR_ACC_HI: rd_data[ACC_W-33:0] = acc_r[ACC_W-1:32];
        ADDR_IDX:    rd_data[PTR_W-1:0] = idx_r;
        ADDR_GEN:    rd_data[PTR_W-1:0] = gen_r;
        ADDR_STEP:   rd_data[PTR_W-1:0] = step_r;
        default:     rd_data = 32'h0000_0000;
      endcase
    end
  end

  // ===========================================================
  // bus response next values
  always_comb begin
    pready_nxt  = 1'b0;
    prdata_nxt  = prdata_r;
    pslverr_nxt = 1'b0;
    // one wait state; held off while an instruction executes
    if (psel_i && penable_i && !pready_r && !exec) begin
      pready_nxt  = 1'b1;
      pslverr_nxt = !reg_hit(paddr_i);
      prdata_nxt  = pwrite_i ? 32'h0000_0000 : rd_data;
    end
  end

  // read data holds its value between answers
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= pready_nxt;
      prdata_r  <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // ===========================================================
  // control and datapath next values
  always_comb begin
    st_nxt      = st_r;
    instr_nxt   = instr_r;
    acc_nxt     = acc_r;
    flags_nxt   = flags_r;
    bad_nxt     = bad_r;
    done_nxt    = 1'b0;
    idx_nxt     = idx_r;
    gen_nxt     = gen_r;
    step_nxt    = step_r;
    if (wr_en) begin
      case (paddr_i)
        ADDR_INSTR: begin
          instr_nxt = pwdata_i;
          if (opc_valid(pwdata_i)) begin
            st_nxt  = ST_EXEC;
            bad_nxt = 1'b0;
          end else begin
            bad_nxt = 1'b1;
          end
        end
        ADDR_STATUS: begin
          // write one to clear the sticky bits
          if (pwdata_i[ST_LIM_BIT]) flags_nxt.lim = 1'b0;
          if (pwdata_i[ST_SOV_BIT]) flags_nxt.sov = 1'b0;
          if (pwdata_i[ST_BAD_BIT]) bad_nxt = 1'b0;
        end
        ADDR_ACC_LO: acc_nxt[31:0] = pwdata_i;
        ADDR_ACC_HI: acc_nxt[ACC_W-1:32] = pwdata_i[ACC_W-33:0];
        ADDR_IDX:    idx_nxt = pwdata_i[PTR_W-1:0];
        ADDR_GEN:    gen_nxt = pwdata_i[PTR_W-1:0];
        ADDR_STEP:   step_nxt = pwdata_i[PTR_W-1:0];
        default:     ;
      endcase
    end
    case (st_r)
      ST_IDLE: ;
      ST_EXEC: begin
        // set wins over any clear in the same cycle
        acc_nxt   = alu_res.acc;
        flags_nxt = alu_res.flags;
        idx_nxt   = dest_ptr;
        gen_nxt   = ptr_mod(gen_r, instr_r[GEN_MOD_LSB +: PMOD_W],
                            step_r);
        done_nxt  = 1'b1;
        st_nxt    = ST_IDLE;
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  // ===========================================================
  // memory words
  generate
    for (genvar i = 0; i < DEPTH; i++) begin : g_mem
      always_comb begin
        // a bus write never meets an executing instruction
        mem_nxt[i] = mem_r[i];
        if (wr_en && mem_hit(paddr_i) &&
            mem_idx(paddr_i) == PTR_W'(i)) begin
          mem_nxt[i] = pwdata_i[DATA_W-1:0];
        end
        if (exec && dest_ptr == PTR_W'(i)) begin
          mem_nxt[i] = mem_r[idx_r];
        end
      end
      always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
          mem_r[i] <= '0;
        end else begin
          mem_r[i] <= mem_nxt[i];
        end
      end
    end
  endgenerate

  // ===========================================================
  // registers
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      st_r      <= ST_IDLE;
      instr_r   <= INSTR_RESET;
      acc_r     <= '0;
      flags_r   <= '0;
      bad_r     <= 1'b0;
      done_r    <= 1'b0;
      idx_r     <= '0;
      gen_r     <= '0;
      step_r    <= '0;
    end else begin
      st_r      <= st_nxt;
      instr_r   <= instr_nxt;
      acc_r     <= acc_nxt;
      flags_r   <= flags_nxt;
      bad_r     <= bad_nxt;
      done_r    <= done_nxt;
      idx_r     <= idx_nxt;
      gen_r     <= gen_nxt;
      step_r    <= step_nxt;
    end
  end

  // ===========================================================
  // outputs
  assign pready_o         = pready_r;
  assign prdata_o         = prdata_r;
  assign pslverr_o        = pslverr_r;
  assign accumulator_40_o = acc_r;
  assign flags_o          = flags_r;
  assign done_o           = done_r;

endmodule // mrsm_top
`default_nettype wire

// [mrsm_top_test.sv]
// self-checking bench for the reverse-subtract mac block
`timescale 1ns/1ps
`default_nettype none
module mrsm_top_test;
  import mrsm_pkg::*;
  logic             sys_clk_i, srst_i, psel, penable, pwrite;
  logic             pready, pslverr, done, e_lim, e_sov;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, prdata;
  logic [ACC_W-1:0] acc;
  mrsm_flags_t      flags;
  int               n_mismatch = 0;
  int               checks_done = 0;
  logic             rm [6] = '{0, 1, 0, 0, 1, 1};
  logic [2:0]       im [6] = '{0, 1, 2, 3, 4, 5};
  int               dst [6] = '{0, 1, 15, 3, 13, 0};
  logic [15:0]      a [6] = '{16'hFFFF, 16'h1234, 16'h0, 16'h2, 16'hFFFF, 16'h1};
  logic [15:0]      b [6] = '{16'hFFFF, 16'h8000, 16'h0, 16'h3, 16'hFFFF, 16'h7FFF};
  logic [39:0]      c [6] = '{40'h1, 40'h0, SAT_MIN, 40'h6, SAT_MAX, 40'h0};

  mrsm_top u_mrsm_top (.sys_clk_i, .srst_i, .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .pready_o(pready), .prdata_o(prdata),
    .pslverr_o(pslverr), .accumulator_40_o(acc), .flags_o(flags),
    .done_o(done));
  mrsm_core_model u_mrsm_core_model (.sys_clk_i, .psel_o(psel),
    .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
    .pwdata_o(pwdata), .pready_i(pready), .prdata_i(prdata),
    .pslverr_i(pslverr));

  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  // ==========
  // common tasks
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [47:0] s, input logic [47:0] x);
    checks_done++;
    if (s !== x) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, s, x);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] ad,
      input logic [31:0] d, output logic [31:0] q, output logic e);
    logic t;
    u_mrsm_core_model.xfer(w, ad, d, q, e, t);
    if (t) begin
      n_mismatch++;
      end_of_test();
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    bus(1'b1, ad, d, q, e);
  endtask
  task automatic exec(input logic [31:0] ins);
    int n;
    wr(ADDR_INSTR, ins);
    for (n = 0; n < 10 && done !== 1'b1; n++) @(posedge sys_clk_i);
    if (done !== 1'b1) begin
      n_mismatch++;
      end_of_test();
    end
  endtask
  // expected accumulator and flags
  function automatic mrsm_alu_res_t exp_res(input logic r,
      input logic [15:0] x, y, input logic [39:0] z);
    logic [41:0] p, f;
    logic [39:0] v;
    logic        ov;
    p = {26'h0, x} * (r ? {{26{y[15]}}, y} : {26'h0, y});
    f = p - {{2{z[39]}}, z} + (r ? 42'h8000 : 42'h0);
    ov = f[41:39] != 3'h0 && f[41:39] != 3'h7;
    v = ov ? (f[41] ? SAT_MIN : SAT_MAX) : f[39:0];
    if (r) v[15:0] = 16'h0;
    return {v, ov, e_lim | ov, !(&v[39:31] || ~|v[39:31]), e_sov | ov,
      p[39:0] < z, v == '0, v[39]};
  endfunction
  // ==========
  // scenarios
  task automatic s_cases();
    mrsm_alu_res_t x;
    logic [31:0]   q;
    logic          e;
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_MEM, {16'h0, a[i]});
      wr(ADDR_MEM + 8'h4, {16'h0, b[i]});
      wr(ADDR_IDX, 32'h0);
      wr(ADDR_GEN, 32'h1);
      wr(ADDR_STEP, 32'h3);
      wr(ADDR_ACC_LO, c[i][31:0]);
      wr(ADDR_ACC_HI, {24'h0, c[i][39:32]});
      x = exp_res(rm[i], a[i], b[i], c[i]);
      e_lim = x.flags.lim;
      e_sov = x.flags.sov;
      exec(u_mrsm_core_model.instr(rm[i], im[i]));
      chk({8'h0, acc}, {8'h0, x.acc});
      chk(48'(flags), 48'(x.flags));
      bus(1'b0, ADDR_MEM + 8'(4 * dst[i]), 32'h0, q, e);
      chk(48'(q), {32'h0, a[i]});
      bus(1'b0, ADDR_IDX, 32'h0, q, e);
      chk(48'(q), 48'(dst[i]));
    end
  endtask
  task automatic s_bad();
    logic [31:0] bad [3] = '{32'h9300_7800, 32'h9400_3800, 32'h9300_3900};
    logic [31:0] q;
    logic        e;
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_INSTR, bad[i]);
      bus(1'b0, ADDR_STATUS, 32'h0, q, e);
      chk(48'(q[8]), 48'h1);
      chk({8'h0, acc}, 48'h0);
      wr(ADDR_STATUS, 32'h0000_0128);
    end
    bus(1'b0, ADDR_STATUS, 32'h0, q, e);
    chk(48'(q[8:0]), 48'h002);
    bus(1'b1, 8'h3C, 32'h1, q, e);
    chk(48'(e), 48'h1);
    bus(1'b0, ADDR_MEM + 8'h2, 32'h0, q, e);
    chk({15'h0, e, q}, {15'h0, 1'b1, 32'h0});
  endtask

  initial begin
    srst_i = 1'b1;
    e_lim = 1'b0;
    e_sov = 1'b0;
    repeat (4) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    chk({8'h0, acc}, 48'h0);
    chk(48'(flags), 48'h0);
    s_cases();
    s_bad();
    end_of_test();
  end
endmodule // mrsm_top_test
`default_nettype wire
